// ### include/status_pkg.sv
// Status reporting package: bit positions, reset values, port structs
package status_pkg;
	localparam int SB_EXT_SUM   = 1;
	localparam int SB_ERR_AVAIL = 2;
	localparam int SB_MSG_AVAIL = 4;
	localparam int SB_EVT_SUM   = 5;
	localparam int SB_MASTER    = 6;
	localparam int SE_OPC       = 0;
	localparam int SE_QUERY_ERR = 2;
	localparam int SE_DEV_ERR   = 3;
	localparam int SE_EXEC_ERR  = 4;
	localparam int SE_CMD_ERR   = 5;
	localparam int SE_POWER_ON  = 7;
	localparam logic [7:0]  SE_USED_MASK   = 8'h00_bd;
	localparam logic [7:0]  SB_USED_MASK   = 8'h00_36;
	localparam logic [15:0] COND_MASK      = 16'h21_1f | 16'h0c_00;
	localparam logic [15:0] EXT_USED_MASK  = 16'h3d_ff;
	localparam logic [7:0]  SE_RESET       = 8'h00_80;
	localparam logic [7:0]  ENA8_RESET     = 8'h00_00;
	localparam logic [15:0] ENA16_RESET    = 16'h00_00;
	localparam logic [15:0] ZERO16         = 16'h00_00;
	localparam int EX_SRC_CHG   = 5;
	localparam int EX_STEP      = 6;
	localparam int EX_PROG      = 7;
	localparam int EX_TRIP      = 12;

	typedef struct packed {
		logic measure_busy;
		logic out_of_range;
		logic storage_busy;
		logic file_build_busy;
		logic trigger_sample_err;
		logic program_prep_busy;
		logic low_limit_active;
		logic high_limit_active;
		logic overtemp_emergency;
	} activity_s;

	typedef struct packed {
		logic source_value_changed;
		logic step_done;
		logic program_done;
		logic output_tripped;
	} ext_pulse_s;

	typedef struct packed {
		logic opc_done;
		logic query_err;
		logic device_err;
		logic exec_err;
		logic cmd_err;
	} std_pulse_s;

	typedef struct packed {
		logic       cls;
		logic       after_terminator;
		logic       read_esr;
		logic       read_ext_event;
		logic       serial_poll_done;
		logic       write_sre;
		logic       write_ese;
		logic       write_ext_ena;
		logic [15:0] wdata;
	} cmd_s;
endpackage : status_pkg

// ### verilog/edge_flag.sv
// Sticky flag bank: sets on rising condition or pulse, clears on request
`timescale 1ns/1ps
module edge_flag (
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic [15:0] cond_in,
	input  wire logic [15:0] cond_mask_in,
	input  wire logic [15:0] pulse_in,
	input  wire logic        clear_in,
	output logic      [15:0] flags_out
);
	import status_pkg::*;
	logic [15:0] prev_q;
	logic [15:0] flags_d;
	wire  [15:0] rise = cond_in & ~prev_q & cond_mask_in;

	// Set wins over a clear in the same cycle
	assign flags_d = ((clear_in ? ZERO16 : flags_out) | rise | pulse_in)
		& EXT_USED_MASK;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prev_q    <= ZERO16;
			flags_out <= ZERO16;
		end else begin
			prev_q    <= cond_in;
			flags_out <= flags_d;
		end
	end
endmodule : edge_flag

// ### verilog/status_report.sv
// Status byte, standard and extended event registers with service request
`timescale 1ns/1ps
module status_report (
	input  wire logic                   clk_in,
	input  wire logic                   rst_b_in,
	input  wire status_pkg::activity_s  activity_in,
	input  wire status_pkg::ext_pulse_s ext_pulse_in,
	input  wire status_pkg::std_pulse_s std_pulse_in,
	input  wire status_pkg::cmd_s       cmd_in,
	input  wire logic                   error_queue_nonempty_in,
	input  wire logic                   output_queue_nonempty_in,
	output logic                        output_queue_clear_out,
	output logic                        service_request_out,
	output logic [7:0]                  stb_query_out,
	output logic [7:0]                  serial_poll_out,
	output logic [7:0]                  standard_event_flags_out,
	output logic [15:0]                 extended_condition_state_out,
	output logic [15:0]                 extended_event_flags_out,
	output logic [7:0]                  sre_out,
	output logic [7:0]                  ese_out,
	output logic [15:0]                 ext_ena_out
);
	import status_pkg::*;

	logic [7:0]  std_q;
	logic [7:0]  std_d;
	logic [7:0]  sre_q;
	logic [7:0]  ese_q;
	logic [15:0] ext_ena_q;
	logic [15:0] cond_q;
	logic [15:0] cond_d;
	logic        rqs_q;
	logic        rqs_d;
	logic        mss_prev_q;
	logic        oq_clear_q;
	logic        pon_q;
	logic [15:0] ext_flags;
	logic [15:0] ext_pulse;
	logic [7:0]  std_set;
	logic [7:0]  status_core;
	logic        mss;
	logic        ext_sum;
	logic        evt_sum;
	logic        std_clear;
	logic        ext_clear;
	logic        cond_valid_q;
	logic        cond_armed_q;
	logic [15:0] cond_edge_mask;
	logic        sre_wr;
	logic        ese_wr;
	logic        ext_ena_wr;
	logic        oq_clear_d;

	// Register strobes decoded from the command word
	assign sre_wr     = cmd_in.write_sre;
	assign ese_wr     = cmd_in.write_ese;
	assign ext_ena_wr = cmd_in.write_ext_ena;
	assign std_clear  = cmd_in.read_esr | cmd_in.cls;
	assign ext_clear  = cmd_in.read_ext_event | cmd_in.cls;
	assign oq_clear_d = cmd_in.cls & cmd_in.after_terminator;

	// Edge detection waits until the condition word and its delayed copy
	// both hold real samples, so idle-high bits do not look like rises
	assign cond_edge_mask = cond_armed_q ? COND_MASK : ZERO16;

	// Condition word: idle-high activity bits are inverted busy or trigger-sample-error inputs
	always_comb begin
		cond_d                = ZERO16;
		cond_d[0]             = ~activity_in.measure_busy;
		cond_d[1]             = activity_in.out_of_range;
		cond_d[2]             = ~activity_in.storage_busy;
		cond_d[3]             = ~activity_in.file_build_busy;
		cond_d[4]             = ~activity_in.trigger_sample_err;
		cond_d[8]             = ~activity_in.program_prep_busy;
		cond_d[10]            = activity_in.low_limit_active;
		cond_d[11]            = activity_in.high_limit_active;
		cond_d[13]            = activity_in.overtemp_emergency;
	end

	always_comb begin
		ext_pulse             = ZERO16;
		ext_pulse[EX_SRC_CHG] = ext_pulse_in.source_value_changed;
		ext_pulse[EX_STEP]    = ext_pulse_in.step_done;
		ext_pulse[EX_PROG]    = ext_pulse_in.program_done;
		ext_pulse[EX_TRIP]    = ext_pulse_in.output_tripped;
	end

	always_comb begin
		std_set               = ENA8_RESET;
		std_set[SE_OPC]       = std_pulse_in.opc_done;
		std_set[SE_QUERY_ERR] = std_pulse_in.query_err;
		std_set[SE_DEV_ERR]   = std_pulse_in.device_err;
		std_set[SE_EXEC_ERR]  = std_pulse_in.exec_err;
		std_set[SE_CMD_ERR]   = std_pulse_in.cmd_err;
		std_set[SE_POWER_ON]  = pon_q;
	end

	edge_flag u_ext_flags (
		.clk_in       (clk_in),
		.rst_b_in     (rst_b_in),
		.cond_in      (cond_q),
		.cond_mask_in (cond_edge_mask),
		.pulse_in     (ext_pulse),
		.clear_in     (ext_clear),
		.flags_out    (ext_flags)
	);

	// Read and clear-status empty the register; new events still land
	assign std_d = ((std_clear ? ENA8_RESET : std_q)
		| std_set) & SE_USED_MASK;

	assign ext_sum = |(ext_flags & ext_ena_q);
	assign evt_sum = |(std_q & ese_q);

	always_comb begin
		status_core               = ENA8_RESET;
		status_core[SB_EXT_SUM]   = ext_sum;
		status_core[SB_ERR_AVAIL] = error_queue_nonempty_in;
		status_core[SB_MSG_AVAIL] = output_queue_nonempty_in;
		status_core[SB_EVT_SUM]   = evt_sum;
	end

	assign mss = |(status_core & sre_q & SB_USED_MASK);

	// Rise of master summary sets; poll or fall clears; a rise wins
	assign rqs_d = (mss & ~mss_prev_q)
		| (rqs_q & mss & ~cmd_in.serial_poll_done);

	assign stb_query_out   = status_core | ({7'h0_0, mss} << SB_MASTER);
	assign serial_poll_out = status_core
		| ({7'h0_0, rqs_q} << SB_MASTER);
	assign service_request_out = rqs_q;
	assign output_queue_clear_out = oq_clear_q;
	assign standard_event_flags_out = std_q;
	assign extended_condition_state_out = cond_q;
	assign extended_event_flags_out = ext_flags;
	assign sre_out = sre_q;
	assign ese_out = ese_q;
	assign ext_ena_out = ext_ena_q;

	// Power-on marker lasts one cycle so bit 7 lands once after restart
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pon_q <= 1'b1;
		end else begin
			pon_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			std_q <= ENA8_RESET;
		end else begin
			std_q <= std_d;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sre_q <= ENA8_RESET;
		end else if (sre_wr) begin
			sre_q <= cmd_in.wdata[7:0] & SB_USED_MASK;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ese_q <= ENA8_RESET;
		end else if (ese_wr) begin
			ese_q <= cmd_in.wdata[7:0];
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ext_ena_q <= ENA16_RESET;
		end else if (ext_ena_wr) begin
			ext_ena_q <= cmd_in.wdata;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cond_q <= ZERO16;
		end else begin
			cond_q <= cond_d;
		end
	end

	// Two-stage arming: first edge fills the condition word, second its copy
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cond_valid_q <= 1'b0;
			cond_armed_q <= 1'b0;
		end else begin
			cond_valid_q <= 1'b1;
			cond_armed_q <= cond_valid_q;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rqs_q      <= 1'b0;
			mss_prev_q <= 1'b0;
		end else begin
			rqs_q      <= rqs_d;
			mss_prev_q <= mss;
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			oq_clear_q <= 1'b0;
		end else begin
			oq_clear_q <= oq_clear_d;
		end
	end
endmodule : status_report

// ### dv/poll_ctrl_model.sv
// Bus controller model that serial-polls after a service request
`timescale 1ns/1ps
module poll_ctrl_model (
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	input  wire logic srq_in,
	input  wire logic slow_in,
	output logic      poll_done_out
);
	logic [2:0] cnt_q;
	// Poll answered after two or five cycles of standing request
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_q <= 3'h0;
			poll_done_out <= 1'b0;
		end else begin
			poll_done_out <= srq_in && cnt_q == (slow_in ? 3'h4 : 3'h1);
			cnt_q <= (srq_in && !poll_done_out) ? cnt_q + 3'h1 : 3'h0;
		end
	end
endmodule : poll_ctrl_model

// ### dv/status_monitor.sv
// Checker for status byte summaries, request flag and clearing
`timescale 1ns/1ps
module status_monitor (
	input wire logic                  clk_in,
	input wire logic                  rst_b_in,
	input wire status_pkg::std_pulse_s std_pulse_in,
	input wire status_pkg::cmd_s      cmd_in,
	input wire logic                  error_queue_nonempty_in,
	input wire logic                  output_queue_nonempty_in,
	input wire logic                  output_queue_clear_out,
	input wire logic                  service_request_out,
	input wire logic [7:0]            stb_query_out,
	input wire logic [7:0]            serial_poll_out,
	input wire logic [7:0]            standard_event_flags_out,
	input wire logic [15:0]           extended_event_flags_out,
	input wire logic [7:0]            sre_out,
	input wire logic [7:0]            ese_out,
	input wire logic [15:0]           ext_ena_out
);
	import status_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	a_master_sum:
	assert property (stb_query_out[6] == |(stb_query_out & sre_out & 8'h00_bf))
	else $error("master summary wrong");
	a_event_sum:
	assert property (stb_query_out[5] == |(standard_event_flags_out & ese_out))
	else $error("event summary wrong");
	a_ext_sum:
	assert property (stb_query_out[1] ==
		|(extended_event_flags_out & ext_ena_out)) else $error("ext summary wrong");
	a_queue_bits:
	assert property (stb_query_out[2] == error_queue_nonempty_in &&
		stb_query_out[4] == output_queue_nonempty_in) else $error("queue bits wrong");
	a_poll_byte:
	assert property (serial_poll_out[6] == service_request_out &&
		serial_poll_out[5:0] == stb_query_out[5:0]) else $error("poll byte wrong");
	a_request_rise:
	assert property ($rose(stb_query_out[6]) |=> service_request_out)
	else $error("request missing");
	a_request_fall:
	assert property (!stb_query_out[6] |=> !service_request_out)
	else $error("request without summary");
	a_poll_clears:
	assert property (cmd_in.serial_poll_done && !$rose(stb_query_out[6]) |=>
		!service_request_out) else $error("poll did not clear request");
	a_unused_zero:
	assert property ((standard_event_flags_out & 8'h00_42) == 8'h00_00 &&
		(extended_event_flags_out & 16'hc200) == 16'h0000) else $error("unused set");
	a_esr_clear:
	assert property ((cmd_in.read_esr || cmd_in.cls) && std_pulse_in == '0 |=>
		standard_event_flags_out == 8'h00_00) else $error("event reg not cleared");
	a_oq_clear:
	assert property (output_queue_clear_out ==
		$past(cmd_in.cls && cmd_in.after_terminator)) else $error("queue clear wrong");
endmodule : status_monitor
bind status_report status_monitor mon (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.std_pulse_in(std_pulse_in), .cmd_in(cmd_in), .sre_out(sre_out),
	.error_queue_nonempty_in(error_queue_nonempty_in), .ese_out(ese_out),
	.output_queue_nonempty_in(output_queue_nonempty_in), .ext_ena_out(ext_ena_out),
	.output_queue_clear_out(output_queue_clear_out), .stb_query_out(stb_query_out),
	.service_request_out(service_request_out), .serial_poll_out(serial_poll_out),
	.standard_event_flags_out(standard_event_flags_out),
	.extended_event_flags_out(extended_event_flags_out));

// ### dv/tb.sv
// Testbench for the status reporting block
`timescale 1ns/1ps
module tb;
	import status_pkg::*;
	logic clk_in, rst_b_in, poll, slow, eq, oq, oqc, srq;
	activity_s act;
	ext_pulse_s xp;
	std_pulse_s sp;
	cmd_s cmd, cmd_w;
	logic [7:0] stb, spb, std, sre, ese;
	logic [15:0] cnd, ext, ena;
	int mismatches = 0, num_checks = 0, pos[5] = '{0, 2, 3, 4, 5};
	always_comb begin
		cmd_w = cmd;
		cmd_w.serial_poll_done = cmd.serial_poll_done | poll;
	end
	status_report dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .activity_in(act),
		.ext_pulse_in(xp), .std_pulse_in(sp), .cmd_in(cmd_w),
		.error_queue_nonempty_in(eq), .output_queue_nonempty_in(oq),
		.output_queue_clear_out(oqc), .service_request_out(srq),
		.stb_query_out(stb), .serial_poll_out(spb), .standard_event_flags_out(std),
		.extended_condition_state_out(cnd), .extended_event_flags_out(ext),
		.sre_out(sre), .ese_out(ese), .ext_ena_out(ena));
	poll_ctrl_model ctl (.clk_in(clk_in), .rst_b_in(rst_b_in), .srq_in(srq),
		.slow_in(slow), .poll_done_out(poll));
	task tick;
		@(posedge clk_in);
		#5;
	endtask : tick
	task send(input logic [7:0] f, input logic [15:0] d);
		cmd = {f, d};
		@(posedge clk_in);
		#1 cmd = '0;
		#4;
	endtask : send
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	initial begin
		#200_000;
		mismatches++;
		give_verdict;
	end
	initial begin
		{rst_b_in, act, xp, sp, cmd, slow, eq, oq} = '0;
		repeat (16) @(posedge clk_in);
		#5 rst_b_in = 1'b1;
		tick;
		chk(std, 8'h80);
		repeat (3) tick;
		send(8'h30, 16'h0000);
		chk(std, 8'h00);
		chk(ext, 16'h0000);
		send(8'h02, 16'h00bd);
		chk(ese, 8'hbd);
		send(8'h04, 16'h00ff);
		chk(sre, 8'h36);
		send(8'h01, 16'hffff);
		for (int i = 0; i < 5; i++) begin
			sp = 5'h10 >> i;
			tick;
			sp = '0;
			chk(std, 16'h1 << pos[i]);
			chk(stb[5], 1'b1);
			send(8'h20, 16'h0000);
			chk(std, 8'h00);
			repeat (8) tick;
		end
		for (int s = 0; s < 2; s++) begin
			{eq, oq} = 2'b11;
			slow = s[0];
			sp = 5'h01;
			tick;
			sp = '0;
			chk(stb[6], 1'b1);
			tick;
			chk(srq, 1'b1);
			for (int k = 0; k < 20 && srq === 1'b1; k++) tick;
			chk(srq, 1'b0);
			chk(stb, 8'h74);
			chk(spb, 8'h34);
			send({1'b1, s[0], 6'h00}, 16'h0000);
			chk(oqc, s[0]);
			chk(std, 8'h00);
			chk(stb, 8'h54);
			{eq, oq} = 2'b00;
			tick;
		end
		act = 9'h1ff;
		repeat (3) tick;
		chk(cnd, 16'h2c02);
		send(8'h10, 16'h0000);
		act = '0;
		repeat (3) tick;
		chk(cnd, 16'h011d);
		chk(ext, 16'h011d);
		chk(stb[1], 1'b1);
		send(8'h10, 16'h0000);
		chk(ext, 16'h0000);
		chk(cnd, 16'h011d);
		xp = 4'hf;
		tick;
		xp = '0;
		chk(ext, 16'h10e0);
		send(8'h80, 16'h0000);
		chk(ext, 16'h0000);
		chk(stb[1], 1'b0);
		give_verdict;
	end
endmodule : tb
